//--- design/sac_pkg.sv
// Shared constants and types for the converter sequencing block
package sac_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_MHZ        = 50;
	localparam int CONV_TIME_NS   = 3800;
	localparam int SLEEP_CONV_NS  = 9800;
	localparam int WAKE_TIME_NS   = 6000;
	localparam int ACQ_TIME_NS    = 300;
	localparam int READ_QUIET_NS  = 300;
	// Longest times round down to whole cycles
	localparam int CONV_CYCLES    = CONV_TIME_NS * CLK_MHZ / 1000;
	localparam int SLEEP_CYCLES   = SLEEP_CONV_NS * CLK_MHZ / 1000;
	localparam int WAKE_CYCLES    = WAKE_TIME_NS * CLK_MHZ / 1000;

	// ****************************************************************
	// Result and serial framing
	// ****************************************************************
	localparam int RES_BITS       = 12;
	localparam int READ_BITS      = 16;
	localparam int LEAD_ZEROS     = READ_BITS - RES_BITS;
	localparam int STEP_CYCLES    = CONV_CYCLES / (RES_BITS + 1);
	localparam int FIFO_WORDS     = 4;

	localparam logic [7:0]  STEP_LAST   = 8'(STEP_CYCLES - 1);
	localparam logic [7:0]  CONV_AGE    = 8'(CONV_CYCLES - 2);
	localparam logic [8:0]  WAKE_LAST   = 9'(WAKE_CYCLES - 1);
	localparam logic [3:0]  BIT_TOP     = 4'(RES_BITS - 1);
	localparam logic [4:0]  SHIFT_LAST  = 5'(READ_BITS - 1);
	localparam logic [4:0]  ZERO_BITS   = 5'(LEAD_ZEROS);
	localparam logic [11:0] MIDSCALE    = 12'h800;
	localparam logic [11:0] SIGN_FLIP   = 12'h800;
	localparam logic [11:0] WORD_RESET  = 12'h000;

	typedef enum logic [1:0]
	{
		SAC_IDLE  = 2'b00,
		SAC_CONV  = 2'b01,
		SAC_SLEEP = 2'b10,
		SAC_WAKE  = 2'b11
	} sac_mode_t;

endpackage

//--- design/sac_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sac_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} sac_fifo_state_t;

	sac_fifo_state_t s;
	sac_fifo_state_t next_s;
	logic            push;
	logic            pop;

	// Depth need not be a power of two
	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = s.cnt != (AW+1)'(DEPTH);
	assign out_valid = s.cnt != '0;
	assign out_data  = s.mem[s.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		next_s = s;
		if (push)
		begin
			next_s.mem[s.wp] = in_data;
			next_s.wp        = next_ptr(s.wp);
		end
		if (pop)
			next_s.rp = next_ptr(s.rp);
		if (push && !pop)
			next_s.cnt = s.cnt + 1'b1;
		else if (pop && !push)
			next_s.cnt = s.cnt - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			s <= '0;
		else
			s <= next_s;
	end

endmodule

//--- design/sac_conv_ctrl.sv
// Conversion sequencing, result coding and serial readout of a 12-bit SAR converter
// Notes on behaviour
// - Start falling edge: hold and begin conversion
// - Steps timed by internal conversion clock
// - Done within 3.8 us, 9.8 us asleep, unless a full result queue stalls the finish
// - Back to tracking at conversion end
// - Auto-sleep mode supported
// - Twelve bits resolved MSB first, one per step
// - Bipolar variant codes two's complement
// - Unipolar variant codes straight binary
// - Transitions at whole LSB multiples
// - Bipolar: all-ones to zero crossing ground
// - Busy high on start, low when done
// - Start low at end: sleep; rise wakes
// - Sixteen clocks: four zeros, twelve bits, release
`timescale 1ns/1ps
module sac_conv_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        convert_start_n,
	input  wire logic        serial_clk,
	input  wire logic        comparator_high,
	input  wire logic        coding_bipolar,
	output logic             busy,
	output logic             track_hold,
	output logic             sleep_mode,
	output logic [11:0]      dac_trial,
	output logic             serial_result_out,
	output logic             serial_result_oe
);
	import sac_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		sac_mode_t   mode;
		logic [2:0]  cnv_sync;
		logic [2:0]  sck_sync;
		logic [7:0]  step_cnt;
		logic [7:0]  conv_age;
		logic [3:0]  bit_idx;
		logic [11:0] trial;
		logic [8:0]  wake_cnt;
		logic        wake_pend;
		logic        busy;
		logic        hold;
		logic        sleep;
		logic        bipolar;
		logic        strap_done;
		logic [15:0] shift;
		logic [4:0]  bit_cnt;
		logic        oe;
		logic [11:0] last_word;
	} sac_state_t;

	sac_state_t  s;
	sac_state_t  next_s;
	logic        cnv_fall;
	logic        cnv_rise;
	logic        cnv_low;
	logic        sck_fall;
	logic        sck_rise;
	logic        step_end;
	logic        read_start;
	logic [11:0] decided;
	logic        push_valid;
	logic [11:0] push_data;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [11:0] fifo_out_data;

	// Keep the decided bit and raise the next trial bit; each trial bit has half the weight of the one before
	function automatic logic [11:0] sar_resolve(input logic [11:0] t, input logic [3:0] idx,
		input logic cmp);
		logic [11:0] r;
		r = t;
		if (!cmp)
			r[idx] = 1'b0;
		if (idx != 4'h0)
			r[idx - 4'h1] = 1'b1;
		sar_resolve = r;
	endfunction

	// ****************************************************************
	// Edge detection on synchronised pins
	// ****************************************************************
	// Only the second and third stages are looked at
	assign cnv_fall   = s.cnv_sync[2] && !s.cnv_sync[1];
	assign cnv_rise   = !s.cnv_sync[2] && s.cnv_sync[1];
	assign cnv_low    = !s.cnv_sync[2] && !s.cnv_sync[1];
	assign sck_fall   = s.sck_sync[2] && !s.sck_sync[1];
	assign sck_rise   = !s.sck_sync[2] && s.sck_sync[1];

	assign step_end   = s.step_cnt == STEP_LAST;
	assign decided    = sar_resolve(s.trial, s.bit_idx, comparator_high);
	assign push_valid = (s.mode == SAC_CONV) && step_end && (s.bit_idx == 4'h0);
	// Offset-binary search result becomes two's complement by flipping the MSB
	assign push_data  = s.bipolar ? (decided ^ SIGN_FLIP) : decided;
	assign read_start = sck_rise && !s.oe && (s.bit_cnt == 5'h00) && !cnv_fall;

	sac_fifo #(
		.WIDTH (RES_BITS),
		.DEPTH (FIFO_WORDS)
	) u_result_fifo (
		.clk       (ref_clk),
		.nrst      (nrst),
		.in_valid  (push_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data),
		.out_valid (fifo_out_valid),
		.out_ready (read_start),
		.out_data  (fifo_out_data)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_s          = s;
		next_s.cnv_sync = {s.cnv_sync[1:0], convert_start_n};
		next_s.sck_sync = {s.sck_sync[1:0], serial_clk};
		// Strap is caught once, just after reset release
		if (!s.strap_done)
		begin
			next_s.bipolar    = coding_bipolar;
			next_s.strap_done = 1'b1;
		end
		unique case (s.mode)
			SAC_IDLE:
			begin
				if (cnv_fall)
				begin
					next_s.mode     = SAC_CONV;
					next_s.hold     = 1'b1;
					next_s.busy     = 1'b1;
					next_s.trial    = MIDSCALE;
					next_s.bit_idx  = BIT_TOP;
					next_s.step_cnt = 8'h00;
					next_s.conv_age = 8'h00;
				end
			end
			SAC_CONV:
			begin
				// Falling edges of the start pin are not looked at here
				if (s.conv_age != 8'hff)
					next_s.conv_age = s.conv_age + 8'h01;
				if (!step_end)
					next_s.step_cnt = s.step_cnt + 8'h01;
				else if (s.bit_idx != 4'h0)
				begin
					next_s.trial    = decided;
					next_s.bit_idx  = s.bit_idx - 4'h1;
					next_s.step_cnt = 8'h00;
				end
				// A full result queue stalls the finish rather than lose a word
				else if (fifo_in_ready)
				begin
					next_s.trial = decided;
					next_s.busy  = 1'b0;
					next_s.hold  = 1'b0;
					next_s.sleep = cnv_low;
					next_s.mode  = cnv_low ? SAC_SLEEP : SAC_IDLE;
				end
			end
			SAC_SLEEP:
			begin
				if (cnv_rise)
				begin
					next_s.mode      = SAC_WAKE;
					next_s.wake_cnt  = 9'h000;
					next_s.wake_pend = 1'b0;
				end
			end
			SAC_WAKE:
			begin
				next_s.wake_cnt = s.wake_cnt + 9'h001;
				if (cnv_fall)
				begin
					next_s.wake_pend = 1'b1;
					next_s.busy      = 1'b1;
				end
				// Hold is delayed until the wake-up time has run out
				if (s.wake_cnt == WAKE_LAST)
				begin
					next_s.sleep = 1'b0;
					if (s.wake_pend || cnv_fall)
					begin
						next_s.mode     = SAC_CONV;
						next_s.hold     = 1'b1;
						next_s.busy     = 1'b1;
						next_s.trial    = MIDSCALE;
						next_s.bit_idx  = BIT_TOP;
						next_s.step_cnt = 8'h00;
						next_s.conv_age = 8'h00;
					end
					else
						next_s.mode = SAC_IDLE;
				end
			end
		endcase

		// ************************************************************
		// Serial readout
		// ************************************************************
		// A start edge drops the output enable and clears the bit count, so a read must not straddle it
		if (cnv_fall)
		begin
			next_s.oe      = 1'b0;
			next_s.bit_cnt = 5'h00;
		end
		else if (read_start)
		begin
			// Whole word taken at once: a read never mixes two conversions
			next_s.last_word = fifo_out_valid ? fifo_out_data : s.last_word;
			next_s.shift     = {4'h0, next_s.last_word};
			next_s.oe        = 1'b1;
		end
		else if (sck_fall && s.oe)
		begin
			next_s.shift   = {s.shift[14:0], 1'b0};
			next_s.bit_cnt = s.bit_cnt + 5'h01;
			if (s.bit_cnt == SHIFT_LAST)
			begin
				next_s.oe      = 1'b0;
				next_s.bit_cnt = 5'h00;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			s           <= '0;
			s.mode      <= SAC_IDLE;
			s.cnv_sync  <= 3'h7;
			s.last_word <= WORD_RESET;
		end
		else
			s <= next_s;
	end

	assign busy              = s.busy;
	assign track_hold        = s.hold;
	assign sleep_mode        = s.sleep;
	assign dac_trial         = s.trial;
	assign serial_result_out = s.shift[15];
	assign serial_result_oe  = s.oe;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	start_holds_a: assert property ((s.mode == SAC_IDLE) && cnv_fall |=> s.hold && s.busy)
		else $error("hold or busy missing after start edge");
	// Past its time a conversion may only sit in its final step, waiting for queue room
	conv_time_a: assert property ((s.mode == SAC_CONV) && (s.conv_age >= CONV_AGE)
		|-> step_end && (s.bit_idx == 4'h0) && !$past(fifo_in_ready))
		else $error("conversion ran past its time");
	track_end_a: assert property ($fell(s.busy) |-> !s.hold && !$past(s.busy, 2) == 1'b0)
		else $error("sampler not tracking at conversion end");
	msb_first_a: assert property ((s.mode == SAC_CONV) && step_end && (s.bit_idx != 4'h0)
		|=> s.bit_idx == $past(s.bit_idx) - 4'h1)
		else $error("bit order broken");
	coding_a: assert property (push_valid |-> push_data[11] == (decided[11] ^ s.bipolar))
		else $error("result coding wrong");
	ignore_start_a: assert property ((s.mode == SAC_CONV) && cnv_fall && !step_end
		|=> (s.mode == SAC_CONV) && s.step_cnt == $past(s.step_cnt) + 8'h01)
		else $error("start edge disturbed a conversion");
	sleep_entry_a: assert property ($fell(s.busy) && $past(cnv_low) |-> s.sleep)
		else $error("sleep not entered with start held low");
	lead_zero_a: assert property (s.oe && (s.bit_cnt < ZERO_BITS) |-> !serial_result_out)
		else $error("leading zero missing");
	release_a: assert property (s.oe && sck_fall && (s.bit_cnt == SHIFT_LAST) && !cnv_fall
		|=> !serial_result_oe ##1 !serial_result_oe)
		else $error("line not released after sixteenth edge");

	conv_done_c: cover property ((s.mode == SAC_CONV) ##[1:200] $fell(s.busy));
	sleep_wake_c: cover property ((s.mode == SAC_SLEEP) ##[1:40] (s.mode == SAC_WAKE));
	full_read_c: cover property (s.oe && sck_fall && (s.bit_cnt == SHIFT_LAST));
	stall_c: cover property ((s.mode == SAC_CONV) && step_end && !fifo_in_ready);

endmodule

//--- tb/sac_host_model.sv
// Host reader that clocks sixteen-bit frames out of the converter
`timescale 1ns/1ps
module sac_host_model (
	input  wire logic ref_clk,
	output logic      serial_clk,
	input  wire logic serial_result_out,
	input  wire logic serial_result_oe
);
	// ********
	// Frame read
	// ********
	initial serial_clk = 1'b0;

	// Clock runs only within a frame and rests low after it; eight system cycles for the first high half, four for every other
	task automatic read_frame(output logic [15:0] word);
		logic bit_seen;
		word = 16'h0000;
		@(posedge ref_clk);
		serial_clk <= 1'b1;
		repeat (8) @(posedge ref_clk);
		for (int i = 0; i < 16; i++)
		begin
			// A released line reads as its inverse, so a missing bit never matches
			bit_seen = serial_result_oe ? serial_result_out : !serial_result_out;
			word = {word[14:0], bit_seen};
			serial_clk <= 1'b0;
			repeat (4) @(posedge ref_clk);
			if (i < 15)
			begin
				serial_clk <= 1'b1;
				repeat (4) @(posedge ref_clk);
			end
		end
	endtask
endmodule

//--- tb/sac_conv_ctrl_tb.sv
// Self-checking testbench for the converter sequencing block
`timescale 1ns/1ps
module sac_conv_ctrl_tb;
	import sac_pkg::*;
	logic        ref_clk = 1'b0;
	logic        nrst;
	logic        convert_start_n;
	logic        comparator_high;
	logic        coding_bipolar;
	wire logic   serial_clk;
	logic        busy;
	logic        track_hold;
	logic        sleep_mode;
	logic [11:0] dac_trial;
	logic        serial_result_out;
	logic        serial_result_oe;
	logic [11:0] ana;
	time         t0;
	int          n_mismatch = 0;
	int          checks = 0;

	always #10 ref_clk = ~ref_clk;
	// Stand-in for the analog comparator
	always @(posedge ref_clk) comparator_high <= (ana >= dac_trial);

	sac_conv_ctrl i_sac_conv_ctrl (.ref_clk(ref_clk), .nrst(nrst),
		.convert_start_n(convert_start_n), .serial_clk(serial_clk),
		.comparator_high(comparator_high), .coding_bipolar(coding_bipolar), .busy(busy),
		.track_hold(track_hold), .sleep_mode(sleep_mode), .dac_trial(dac_trial),
		.serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));
	sac_host_model i_sac_host_model (.ref_clk(ref_clk), .serial_clk(serial_clk),
		.serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));

	// ********
	// Shared tasks
	// ********
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic do_reset(input logic bip);
		nrst <= 1'b0;
		coding_bipolar <= bip;
		cyc(10);
		check("reset state", 16'h0000, {dac_trial, busy, track_hold, sleep_mode, serial_result_oe});
		nrst <= 1'b1;
		cyc(4);
	endtask

	task automatic start_conv(input logic [11:0] a, input logic keep_low);
		ana <= a;
		convert_start_n <= 1'b0;
		t0 = $time;
		cyc(6);
		check("busy and hold", 16'h0003, {14'h0000, busy, track_hold});
		if (!keep_low)
		begin
			convert_start_n <= 1'b1;
			cyc(40);
			convert_start_n <= 1'b0;
			cyc(5);
			convert_start_n <= 1'b1;
		end
	endtask

	task automatic end_conv(input int lo, input int hi);
		int c;
		int el;
		c = 0;
		while (busy === 1'b1 && c < 2000)
		begin
			cyc(1);
			c++;
		end
		el = int'(($time - t0) / 20);
		check("conversion time", 16'h0001, {15'h0000, el >= lo && el <= hi});
		check("track after end", 16'h0000, {15'h0000, track_hold});
		cyc(20);
	endtask

	task automatic read_check(input logic [11:0] exp);
		logic [15:0] w;
		i_sac_host_model.read_frame(w);
		check("frame", {4'h0, exp}, w);
		cyc(5);
		check("line released", 16'h0000, {15'h0000, serial_result_oe});
		cyc(20);
	endtask

	task automatic conv_read(input logic [11:0] a, input logic [11:0] exp);
		start_conv(a, 1'b0);
		end_conv(RES_BITS * STEP_CYCLES, CONV_CYCLES);
		read_check(exp);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_bipolar();
		logic [11:0] a [4] = '{12'h7ff, 12'h800, 12'hfff, 12'h000};
		logic [11:0] e [4] = '{12'hfff, 12'h000, 12'h7ff, 12'h800};
		do_reset(1'b1);
		foreach (a[i]) conv_read(a[i], e[i]);
		$display("Test bipolar done");
	endtask

	task automatic t_unipolar();
		logic [11:0] a [4] = '{12'h000, 12'hfff, 12'h5a3, 12'h001};
		do_reset(1'b0);
		foreach (a[i]) conv_read(a[i], a[i]);
		$display("Test unipolar done");
	endtask

	task automatic t_sleep();
		start_conv(12'h2c4, 1'b1);
		end_conv(RES_BITS * STEP_CYCLES, CONV_CYCLES);
		check("asleep", 16'h0001, {15'h0000, sleep_mode});
		read_check(12'h2c4);
		ana <= 12'h9e1;
		convert_start_n <= 1'b1;
		t0 = $time;
		cyc(20);
		convert_start_n <= 1'b0;
		cyc(40);
		convert_start_n <= 1'b1;
		end_conv(WAKE_CYCLES + RES_BITS * STEP_CYCLES, SLEEP_CYCLES);
		check("awake", 16'h0000, {15'h0000, sleep_mode});
		read_check(12'h9e1);
		$display("Test sleep done");
	endtask

	task automatic t_fifo();
		logic [11:0] a [5] = '{12'h111, 12'h222, 12'h333, 12'h444, 12'h555};
		for (int i = 0; i < 4; i++)
		begin
			start_conv(a[i], 1'b0);
			end_conv(RES_BITS * STEP_CYCLES, CONV_CYCLES);
		end
		start_conv(a[4], 1'b0);
		cyc(250);
		check("stall on full", 16'h0001, {15'h0000, busy});
		read_check(a[0]);
		end_conv(0, 2000);
		for (int i = 1; i < 5; i++) read_check(a[i]);
		read_check(a[4]);
		$display("Test fifo done");
	endtask

	// Wake-up with no start edge must fall back to the awake idle state
	task automatic t_wake_idle();
		start_conv(12'h3b7, 1'b1);
		end_conv(RES_BITS * STEP_CYCLES, CONV_CYCLES);
		read_check(12'h3b7);
		convert_start_n <= 1'b1;
		cyc(20);
		check("waking", 16'h0001, {15'h0000, sleep_mode});
		cyc(WAKE_CYCLES);
		check("idle after wake", 16'h0000, {14'h0000, sleep_mode, busy});
		conv_read(12'h4d2, 12'h4d2);
		$display("Test wake idle done");
	endtask

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		nrst = 1'b0;
		convert_start_n = 1'b1;
		coding_bipolar = 1'b0;
		ana = 12'h000;
		t_bipolar();
		t_unipolar();
		t_sleep();
		t_fifo();
		t_wake_idle();
		complete_run();
	end

	initial
	begin
		cyc(50000);
		n_mismatch++;
		complete_run();
	end
endmodule
